// ### bench/tb_top.sv
// Self-checking bench joining CPU end and unit end
`timescale 1ns/1ps
module tb_top;
   import uwc_pkg::*;
   logic clk_i, srst_i = 1'b1, req_i = 1'b0, slave_rack_i = 1'b0, indirect_i = 1'b0, scan_i = 1'b0;
   logic [15:0] code_i = 16'h0000, src_i = 16'h0000, count_bcd_i = 16'h0001, ind_addr_i = 16'h0000;
   logic [4:0] unit_i = 5'h00;
   logic [15:0] cfg_word_i = 16'h0000, wk = 16'h0000, handler_declared_i = 16'h0004;
   logic [2:0] cfg_index_i = 3'h0, sc = 3'h0;
   logic cfg_we_i = 1'b0, irq_enable_i = 1'b1, err_raise_i = 1'b0;
   logic [7:0] fetch_addr_i = 8'h00;
   wire logic [15:0] word_i = wk + 16'ha000;
   wire logic [15:0] fetch_data_o;
   wire logic [3:0] handler_num_o, err_history_count_o;
   wire logic handler_done_flag_o, irq_fail_flag_o, err_active_o, busy_o, handler_run_o, word_take_o;
   wire logic instruction_error_flag_o, equal_completion_flag_o;
   int miscompares = 0, tests_run = 0, cyc = 0, ffc = 0, wtc = 0;
   uwc_if lk();
   uwc_cpu u_uwc_cpu(.clk_i, .srst_i, .link(lk), .req_i, .code_i, .src_i, .count_bcd_i, .unit_i,
      .slave_rack_i, .indirect_i, .ind_addr_i, .word_i, .scan_i, .word_take_o, .busy_o,
      .instruction_error_flag_o, .equal_completion_flag_o);
   uwc_unit u_uwc_unit(.clk_i, .srst_i, .link(lk), .cfg_word_i, .cfg_index_i, .cfg_we_i, .irq_enable_i,
      .handler_declared_i, .fetch_addr_i, .err_raise_i, .fetch_data_o, .handler_run_o, .handler_num_o,
      .handler_done_flag_o, .irq_fail_flag_o, .err_active_o, .err_history_count_o);
   uwc_link_monitor u_uwc_link_monitor(.clk_i, .srst_i, .cmd_valid(lk.cmd_valid), .cmd_code(lk.cmd_code),
      .cmd_src(lk.cmd_src), .cmd_count(lk.cmd_count), .data_valid(lk.data_valid), .cmd_done(lk.cmd_done),
      .cmd_ok(lk.cmd_ok));
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // One scan is eight clocks
   always @(negedge clk_i) begin
      sc <= sc + 3'h1;
      scan_i <= sc == 3'h7;
   end
   always @(posedge clk_i) begin
      wk <= wk + 16'(lk.data_valid);
      ffc <= ffc + int'(irq_fail_flag_o);
      wtc <= wtc + int'(word_take_o);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         results();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic results();
      $display("tests_run %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : results
   task automatic cmd(input logic [15:0] c, input logic [15:0] s, input logic [15:0] n);
      int t;
      @(negedge clk_i);
      {code_i, src_i, count_bcd_i, req_i} = {c, s, n, 1'b1};
      @(negedge clk_i);
      req_i = 1'b0;
      for (t = 0; t < 400 && busy_o !== 1'b0; t++) @(negedge clk_i);
      check(16'(busy_o), 16'h0000);
      @(negedge clk_i);
   endtask : cmd
   task automatic cfg(input logic [2:0] i, input logic [15:0] w);
      @(negedge clk_i);
      {cfg_index_i, cfg_word_i, cfg_we_i} = {i, w, 1'b1};
      @(negedge clk_i);
      cfg_we_i = 1'b0;
   endtask : cfg
   task automatic t_write(input logic [7:0] ofs, input logic [15:0] nb, input int n);
      logic [15:0] w0;
      int wt0;
      w0 = word_i;
      wt0 = wtc;
      cmd({UWC_CC_SHM_HI, ofs}, 16'h0000, nb);
      check(16'(equal_completion_flag_o), 16'h0001);
      check(16'(instruction_error_flag_o), 16'h0000);
      check(16'(wtc - wt0), 16'(n));
      for (int k = 0; k < n; k++) begin
         @(negedge clk_i);
         fetch_addr_i = 8'h20 + ofs + 8'(k);
         @(negedge clk_i);
         check(fetch_data_o, w0 + 16'(k));
      end
      $display("write test done");
   endtask : t_write
   task automatic t_bad();
      logic [15:0] nb [7] = '{16'h0000, 16'h0129, 16'h00a1, 16'h0001, 16'h0001, 16'h0001, 16'h0001};
      for (int k = 0; k < 7; k++) begin
         {unit_i, slave_rack_i, indirect_i} = {(k == 3) ? 5'h10 : 5'h00, k == 4, k >= 5};
         ind_addr_i = (k == 5) ? 16'h6657 : 16'h66a0;
         cmd(16'h0000, 16'h0000, nb[k]);
         check(16'(instruction_error_flag_o), 16'h0001);
         check(16'(equal_completion_flag_o), 16'h0000);
         // Clean operands between cases so each flag is freshly raised
         {unit_i, slave_rack_i, indirect_i} = 7'h00;
         cmd(16'h0000, 16'h0000, 16'h0001);
         check(16'(instruction_error_flag_o), 16'h0000);
      end
      {ind_addr_i, indirect_i} = {16'h6656, 1'b1};
      cmd(16'h0000, 16'h0000, 16'h0001);
      indirect_i = 1'b0;
      check(16'(instruction_error_flag_o), 16'h0000);
      $display("operand test done");
   endtask : t_bad
   task automatic t_irq();
      logic f0;
      int c0;
      f0 = handler_done_flag_o;
      cmd(UWC_CC_IRQ, 16'h0002, 16'h0001);
      check(16'(handler_num_o), 16'h0002);
      check(16'(handler_run_o), 16'h0001);
      repeat (10) @(negedge clk_i);
      check(16'(handler_run_o), 16'h0000);
      check(16'(handler_done_flag_o), 16'(!f0));
      {irq_enable_i, c0} = {1'b0, ffc};
      cmd(UWC_CC_IRQ, 16'h0002, 16'h0001);
      repeat (30) @(negedge clk_i);
      check(16'(ffc - c0), 16'h0008);
      check(16'(instruction_error_flag_o), 16'h0001);
      check(16'(equal_completion_flag_o), 16'h0000);
      irq_enable_i = 1'b1;
      $display("interrupt test done");
   endtask : t_irq
   task automatic t_errclr();
      logic [3:0] h0;
      @(negedge clk_i);
      err_raise_i = 1'b1;
      @(negedge clk_i);
      err_raise_i = 1'b0;
      h0 = err_history_count_o;
      check(16'(err_active_o), 16'h0001);
      cmd(UWC_CC_ERRCLR, UWC_ERRCLR_SRC, 16'h0001);
      check(16'(err_active_o), 16'h0000);
      check(16'(err_history_count_o), 16'(h0 + 4'h1));
      // Unlisted code is answered as a failed transfer
      cmd(16'h1200, 16'h0000, 16'h0001);
      check(16'(instruction_error_flag_o), 16'h0001);
      check(16'(equal_completion_flag_o), 16'h0000);
      $display("error clear test done");
   endtask : t_errclr
   initial begin
      repeat (5) @(negedge clk_i);
      srst_i = 1'b0;
      // Index five is a decoy for the base word
      cfg(3'h5, 16'h0050);
      cfg(3'h6, 16'h0020);
      t_write(8'h05, 16'h0003, 3);
      t_write(8'hf0, 16'h0128, 128);
      t_bad();
      t_irq();
      t_errclr();
      results();
   end
endmodule : tb_top

// ### bench/uwc_link_monitor.sv
// Protocol checker for the link between the CPU end and the unit end
`timescale 1ns/1ps
module uwc_link_monitor
   import uwc_pkg::*;
(
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic cmd_valid,
   input wire logic [15:0] cmd_code,
   input wire logic [15:0] cmd_src,
   input wire logic [7:0] cmd_count,
   input wire logic data_valid,
   input wire logic cmd_done,
   input wire logic cmd_ok
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   wire logic is_wr = cmd_code[15:8] == UWC_CC_SHM_HI;
   logic wr_q;
   logic [7:0] cnt_q;
   logic [7:0] seen_q;
   // Words are counted per command, so a short burst shows at done
   always_ff @(posedge clk_i) begin
      if (srst_i || cmd_valid) begin
         wr_q <= !srst_i && is_wr;
         cnt_q <= cmd_count;
         seen_q <= 8'h00;
      end else if (data_valid) begin
         seen_q <= seen_q + 8'h01;
      end
   end
   sequence s_wr_req;
      cmd_valid && is_wr && cmd_count != 8'h00;
   endsequence
   sequence s_ctl_req;
      cmd_valid && !is_wr;
   endsequence
   a_write_streams: assert property (s_wr_req |-> ##[1:3] data_valid)
      else $error("write sent no data");
   a_write_count: assert property (cmd_done && wr_q |-> seen_q == cnt_q)
      else $error("word count differs");
   a_write_ok: assert property (cmd_done && wr_q && cnt_q != 8'h00 |-> cmd_ok)
      else $error("write not completed");
   a_data_in_write: assert property (data_valid |-> wr_q && !cmd_done)
      else $error("data outside a write");
   a_ctl_answer: assert property (s_ctl_req |-> ##3 cmd_done)
      else $error("control answer late");
   a_errclr_ok: assert property (cmd_valid && cmd_code == UWC_CC_ERRCLR && cmd_src == UWC_ERRCLR_SRC
      |-> ##3 (cmd_done && cmd_ok))
      else $error("error clear refused");
   a_ok_qualified: assert property (cmd_ok |-> cmd_done)
      else $error("ok without done");
   a_done_pulse: assert property (cmd_done |=> !cmd_done && !cmd_valid)
      else $error("done not a pulse");
   a_done_after_data: assert property ($fell(data_valid) |-> ##[0:2] cmd_done)
      else $error("no done after data");
endmodule : uwc_link_monitor

// ### inc/uwc_if.sv
// Link between the issuing CPU and the unit command port
`timescale 1ns/1ps
interface uwc_if;
   logic cmd_valid;
   logic [15:0] cmd_code;
   logic [15:0] cmd_src;
   logic [7:0] cmd_count;
   logic data_valid;
   logic [15:0] data_word;
   logic cmd_done;
   logic cmd_ok;
   logic scan_tick;

   modport cpu (output cmd_valid, output cmd_code, output cmd_src, output cmd_count,
      output data_valid, output data_word, output scan_tick, input cmd_done, input cmd_ok);
   modport unit (input cmd_valid, input cmd_code, input cmd_src, input cmd_count,
      input data_valid, input data_word, input scan_tick, output cmd_done, output cmd_ok);
endinterface : uwc_if

// ### inc/uwc_pkg.sv
// Shared constants and types for the unit write command port
package uwc_pkg;
   localparam int UWC_DW = 16;
   localparam logic [7:0] UWC_CC_SHM_HI = 8'h00;
   localparam logic [15:0] UWC_CC_IRQ = 16'hcc00;
   localparam logic [15:0] UWC_CC_ERRCLR = 16'hec00;
   localparam logic [15:0] UWC_ERRCLR_SRC = 16'h0000;
   localparam int UWC_MAX_WORDS = 128;
   localparam logic [15:0] UWC_MAX_IND_ADDR = 16'h6656;
   localparam logic [3:0] UWC_MAX_UNIT = 4'hf;
   localparam int UWC_CFG_BASE_OFS = 6;
   localparam logic [15:0] UWC_BASE_RST = 16'h0000;
   localparam int UWC_IRQ_FAIL_SCANS = 1;
   localparam int UWC_HANDLER_CYC = 4;

   typedef enum logic [2:0] {
      UWC_IDLE = 3'b000,
      UWC_CMD = 3'b001,
      UWC_DATA = 3'b011,
      UWC_DONE = 3'b010,
      UWC_FAIL = 3'b110
   } uwc_state_t;

   // True when every nibble is a decimal digit
   function automatic logic uwc_is_bcd(input logic [15:0] v);
      uwc_is_bcd = (v[3:0] < 4'ha) && (v[7:4] < 4'ha) && (v[11:8] < 4'ha) && (v[15:12] < 4'ha);
   endfunction : uwc_is_bcd

   function automatic logic [15:0] uwc_bcd_to_bin(input logic [15:0] v);
      uwc_bcd_to_bin = 16'(v[15:12] * 1000 + v[11:8] * 100 + v[7:4] * 10 + v[3:0]);
   endfunction : uwc_bcd_to_bin
endpackage : uwc_pkg

// ### src/uwc_cpu.sv
// CPU end: checks operands, issues commands, sets error and equal flags
`timescale 1ns/1ps
module uwc_cpu
   import uwc_pkg::*;
(
   input wire logic clk_i,
   input wire logic srst_i,
   uwc_if.cpu link,
   input wire logic req_i,
   input wire logic [15:0] code_i,
   input wire logic [15:0] src_i,
   input wire logic [15:0] count_bcd_i,
   input wire logic [4:0] unit_i,
   input wire logic slave_rack_i,
   input wire logic indirect_i,
   input wire logic [15:0] ind_addr_i,
   input wire logic [15:0] word_i,
   input wire logic scan_i,
   output logic word_take_o,
   output logic busy_o,
   output logic instruction_error_flag_o,
   output logic equal_completion_flag_o
);
   logic [7:0] left;
   logic active;
   logic data_phase;
   logic lead;
   logic want_data;

   wire is_shm = code_i[15:8] == UWC_CC_SHM_HI;
   wire [15:0] cnt_bin = uwc_bcd_to_bin(count_bcd_i);
   wire bad_cnt = is_shm && (!uwc_is_bcd(count_bcd_i) || cnt_bin == 16'd0 || cnt_bin > 16'(UWC_MAX_WORDS));
   wire bad_ind = indirect_i && (!uwc_is_bcd(ind_addr_i) || ind_addr_i > UWC_MAX_IND_ADDR);
   wire bad_unit = unit_i > {1'b0, UWC_MAX_UNIT} || slave_rack_i;
   wire bad = bad_cnt || bad_ind || bad_unit;
   wire send_word = data_phase && left != 8'h00;

   assign link.scan_tick = scan_i;
   assign link.data_word = word_i;
   assign link.data_valid = send_word;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         active <= 1'b0;
         data_phase <= 1'b0;
         left <= '0;
         lead <= 1'b0;
         want_data <= 1'b0;
         link.cmd_valid <= 1'b0;
         link.cmd_code <= '0;
         link.cmd_src <= '0;
         link.cmd_count <= '0;
         instruction_error_flag_o <= 1'b0;
         equal_completion_flag_o <= 1'b0;
         word_take_o <= 1'b0;
         busy_o <= 1'b0;
      end else begin
         link.cmd_valid <= 1'b0;
         word_take_o <= send_word;
         lead <= link.cmd_valid;
         if (!active && req_i) begin
            if (bad) begin
               instruction_error_flag_o <= 1'b1;
               equal_completion_flag_o <= 1'b0;
            end else begin
               active <= 1'b1;
               busy_o <= 1'b1;
               data_phase <= 1'b0;
               want_data <= is_shm;
               left <= is_shm ? cnt_bin[7:0] : 8'h00;
               link.cmd_valid <= 1'b1;
               link.cmd_code <= code_i;
               link.cmd_src <= src_i;
               link.cmd_count <= is_shm ? cnt_bin[7:0] : 8'h00;
            end
         end else if (active) begin
            // Words wait until the unit has left its command state
            if (lead && want_data) begin
               data_phase <= 1'b1;
            end
            if (send_word) begin
               left <= left - 8'h01;
            end
            if (link.cmd_done) begin
               active <= 1'b0;
               busy_o <= 1'b0;
               data_phase <= 1'b0;
               instruction_error_flag_o <= !link.cmd_ok;
               equal_completion_flag_o <= link.cmd_ok;
            end
         end
      end
   end
endmodule : uwc_cpu

// ### src/uwc_unit.sv
// Unit end: decodes write commands, shared memory, interrupts, error clear
//
// Function
// - Code 00xx writes words at base plus offset
// - Base comes from configuration word six
// - Writes complete without any fetch command
// - Code cc00 runs handler matching source number
// - Issuer supplies a declared interrupt number
// - Code ec00 with zero source clears errors
// - CPU flags bad or oversized word count
// - CPU flags bad indirect source address
// - CPU flags unit number out of range
// - CPU flags failed transfer, clears when valid
// - CPU equality flag shows write success
// - Handler completion toggles the completed flag
// - Refused interrupt pulses fail flag one scan
`timescale 1ns/1ps
module uwc_unit
   import uwc_pkg::*;
#(
   parameter int MEM_WORDS = 256,
   parameter int AW = 8,
   parameter int NUM_HANDLERS = 16
) (
   input wire logic clk_i,
   input wire logic srst_i,
   uwc_if.unit link,
   input wire logic [15:0] cfg_word_i,
   input wire logic [2:0] cfg_index_i,
   input wire logic cfg_we_i,
   input wire logic irq_enable_i,
   input wire logic [NUM_HANDLERS-1:0] handler_declared_i,
   input wire logic [AW-1:0] fetch_addr_i,
   input wire logic err_raise_i,
   output logic [15:0] fetch_data_o,
   output logic handler_run_o,
   output logic [3:0] handler_num_o,
   output logic handler_done_flag_o,
   output logic irq_fail_flag_o,
   output logic err_active_o,
   output logic [3:0] err_history_count_o
);
   logic [15:0] shm [MEM_WORDS];
   logic [15:0] host_write_base_config;
   uwc_state_t state;
   logic [AW-1:0] wr_addr;
   logic [7:0] words_left;
   logic [2:0] hcnt;
   logic fail_pending;
   logic done_r;
   logic ok_r;

   wire [7:0] code_hi = link.cmd_code[15:8];
   wire is_shm = code_hi == UWC_CC_SHM_HI;
   wire is_irq = link.cmd_code == UWC_CC_IRQ;
   wire is_eclr = (link.cmd_code == UWC_CC_ERRCLR) && (link.cmd_src == UWC_ERRCLR_SRC);
   wire [3:0] irq_num = link.cmd_src[3:0];
   wire irq_accept = irq_enable_i && !handler_run_o && handler_declared_i[irq_num];
   wire [AW-1:0] start_addr = AW'(host_write_base_config + {8'h00, link.cmd_code[7:0]});
   wire take = (state == UWC_IDLE) && link.cmd_valid;
   wire in_cmd = state == UWC_CMD;
   wire shm_go = is_shm && (link.cmd_count != 8'h00);
   // Unknown codes and refused interrupts answer fail
   wire cmd_fail = is_shm || (is_irq && !irq_accept) || !(is_irq || is_eclr);
   wire irq_start = in_cmd && is_irq && irq_accept;
   // refused interrupt arms the fail flag
   wire irq_refuse = in_cmd && is_irq && !irq_accept;
   // clear acts only on a standing error
   wire eclr_hit = in_cmd && is_eclr && err_active_o;
   // every valid beat stores a word
   wire shm_wr = (state == UWC_DATA) && link.data_valid;
   wire last_word = words_left == 8'h01;
   wire answer = (state == UWC_DONE) || (state == UWC_FAIL);

   assign link.cmd_done = done_r;
   assign link.cmd_ok = ok_r;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         host_write_base_config <= UWC_BASE_RST;
      end else if (cfg_we_i && cfg_index_i == 3'(UWC_CFG_BASE_OFS)) begin
         host_write_base_config <= cfg_word_i;
      end
   end

   // ascending memory fill, no fetch needed
   always_ff @(posedge clk_i) begin
      if (shm_wr) begin
         shm[wr_addr] <= link.data_word;
      end
   end

   // Fetch side may read at any time; it never gates a write
   always_ff @(posedge clk_i) begin
      fetch_data_o <= shm[fetch_addr_i];
   end

   // Answer is a one-cycle pulse; ok only means something beside done
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         done_r <= 1'b0;
         ok_r <= 1'b0;
      end else begin
         done_r <= answer;
         ok_r <= (state == UWC_DONE);
      end
   end

   // Gray-coded walk: idle, command, data, done
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state <= UWC_IDLE;
         wr_addr <= '0;
         words_left <= '0;
      end else begin
         case (state)
            UWC_IDLE: begin
               if (take) begin
                  state <= UWC_CMD;
               end
            end
            UWC_CMD: begin
               if (shm_go) begin
                  wr_addr <= start_addr;
                  words_left <= link.cmd_count;
                  state <= UWC_DATA;
               end else if (cmd_fail) begin
                  state <= UWC_FAIL;
               end else begin
                  state <= UWC_DONE;
               end
            end
            UWC_DATA: begin
               if (shm_wr) begin
                  wr_addr <= wr_addr + AW'(1);
                  words_left <= words_left - 8'h01;
                  if (last_word) begin
                     state <= UWC_DONE;
                  end
               end
            end
            UWC_DONE: begin
               state <= UWC_IDLE;
            end
            default: begin
               state <= UWC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         handler_run_o <= 1'b0;
         handler_num_o <= '0;
         hcnt <= '0;
         handler_done_flag_o <= 1'b0;
      end else if (irq_start) begin
         handler_run_o <= 1'b1;
         handler_num_o <= irq_num;
         hcnt <= 3'(UWC_HANDLER_CYC - 1);
      end else if (handler_run_o) begin
         if (hcnt == 3'd0) begin
            handler_run_o <= 1'b0;
            handler_done_flag_o <= ~handler_done_flag_o;
         end else begin
            hcnt <= hcnt - 3'd1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         fail_pending <= 1'b0;
         irq_fail_flag_o <= 1'b0;
      end else begin
         if (irq_refuse) begin
            fail_pending <= 1'b1;
         end else if (link.scan_tick) begin
            fail_pending <= 1'b0;
         end
         if (link.scan_tick) begin
            irq_fail_flag_o <= fail_pending;
         end
      end
   end

   // clear into history; new error wins over clear
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         err_active_o <= 1'b0;
         err_history_count_o <= '0;
      end else if (err_raise_i) begin
         err_active_o <= 1'b1;
      end else if (eclr_hit) begin
         err_active_o <= 1'b0;
         err_history_count_o <= err_history_count_o + 4'd1;
      end
   end
endmodule : uwc_unit
